//--- rtl/czd_pkg.sv
// Shared encodings, field positions and carrier types for the compressed extension decoder.
// Assumes a 16-bit parcel already aligned by fetch; quadrant 2'h3 never reaches this block.
package czd_pkg;
	// Quadrant and major function codes.
	localparam logic [1:0] Q0 = 2'h0;
	localparam logic [1:0] Q1 = 2'h1;
	localparam logic [1:0] Q2 = 2'h2;
	localparam logic [5:0] F6_LBU = 6'h20;
	localparam logic [5:0] F6_LH = 6'h21;
	localparam logic [5:0] F6_SB = 6'h22;
	localparam logic [5:0] F6_SH = 6'h23;
	localparam logic [5:0] F6_CA = 6'h27;
	localparam logic [5:0] F6_JT = 6'h28;
	localparam logic [5:0] F6_MV = 6'h2b;
	localparam logic [5:0] F6_PPA = 6'h2e;
	localparam logic [5:0] F6_PPB = 6'h2f;
	localparam logic [2:0] F3_FD = 3'h1;
	localparam logic [2:0] F3_FLW = 3'h3;
	localparam logic [2:0] F3_FSD = 3'h5;
	localparam logic [2:0] F3_FSW = 3'h7;
	localparam logic [1:0] FN2_MUL = 2'h2;
	localparam logic [1:0] FN2_CU = 2'h3;
	localparam logic [1:0] FN2_MVSA = 2'h1;
	localparam logic [1:0] FN2_MVA = 2'h3;
	localparam logic [1:0] PP_LO = 2'h0;
	localparam logic [1:0] PP_HI = 2'h2;
	localparam logic [4:0] CU_ZEXTB = 5'h18;
	localparam logic [4:0] CU_SEXTB = 5'h19;
	localparam logic [4:0] CU_ZEXTH = 5'h1a;
	localparam logic [4:0] CU_SEXTH = 5'h1b;
	localparam logic [4:0] CU_ZEXTW = 5'h1c;
	localparam logic [4:0] CU_NOT = 5'h1d;
	localparam logic [7:0] JT_JALT_MIN = 8'h20;
	// Field positions inside the parcel.
	localparam int F6_HI = 15;
	localparam int F6_LO = 10;
	localparam int F3_HI = 15;
	localparam int F3_LO = 13;
	localparam int R1_HI = 9;
	localparam int R1_LO = 7;
	localparam int R2_HI = 4;
	localparam int R2_LO = 2;
	localparam int FN2_HI = 6;
	localparam int FN2_LO = 5;
	localparam int FN1_BIT = 6;
	localparam int UIMM1_BIT = 5;
	localparam int UIMM0_BIT = 6;
	localparam int CU_HI = 6;
	localparam int CU_LO = 2;
	localparam int RL_HI = 7;
	localparam int RL_LO = 4;
	localparam int SP_HI = 3;
	localparam int SP_LO = 2;
	localparam int PPF_HI = 9;
	localparam int PPF_LO = 8;
	localparam int JT_HI = 9;
	localparam int JT_LO = 2;
	localparam int QD_HI = 1;
	localparam int QD_LO = 0;
	// Register numbers and list limits.
	localparam logic [4:0] REG_RA = 5'h01;
	localparam logic [4:0] REG_SP = 5'h02;
	localparam logic [4:0] REG_A0 = 5'h0a;
	localparam logic [1:0] PRIME_BASE = 2'h1;
	localparam logic [4:0] SREG_LOW = 5'h08;
	localparam logic [4:0] SREG_HIGH = 5'h12;
	localparam logic [3:0] RLIST_MIN = 4'h4;
	localparam logic [3:0] RLIST_BIAS = 4'h3;
	localparam logic [3:0] RLIST_ALL = 4'hf;
	localparam logic [3:0] RCNT_MAX = 4'hd;
	localparam logic [3:0] RCNT_GAP = 4'hc;

	typedef enum logic [4:0] {
		OP_NONE = 5'h00, OP_LBU = 5'h01, OP_LHU = 5'h02, OP_LH = 5'h03,
		OP_SB = 5'h04, OP_SH = 5'h05, OP_ZEXTB = 5'h06, OP_SEXTB = 5'h07,
		OP_ZEXTH = 5'h08, OP_SEXTH = 5'h09, OP_ZEXTW = 5'h0a, OP_NOT = 5'h0b,
		OP_MUL = 5'h0c, OP_PUSH = 5'h0d, OP_POP = 5'h0e, OP_POPRET = 5'h0f,
		OP_POPRETZ = 5'h10, OP_MVSA01 = 5'h11, OP_MVA01S = 5'h12, OP_JT = 5'h13,
		OP_JALT = 5'h14, OP_FLW = 5'h15, OP_FSW = 5'h16, OP_FLD = 5'h17,
		OP_FSD = 5'h18, OP_RSVD = 5'h19
	} czd_op_t;

	typedef struct packed {
		logic zca;
		logic f;
		logic d;
		logic mul;
		logic zbb;
		logic zba;
		logic zicsr;
		logic stateen;
		logic want_zcf;
		logic want_zcd;
		logic want_zcb;
		logic want_zcmp;
		logic want_zcmt;
	} czd_cfg_t;

	typedef struct packed {
		logic zcf;
		logic zcd;
		logic zcb;
		logic zcmp;
		logic zcmt;
		logic jvt_stateen;
	} czd_en_t;

	typedef struct packed {
		logic valid;
		logic claimed;
		logic illegal;
		czd_op_t op;
		logic [5:0] major_function_field;
		logic [4:0] rd;
		logic [4:0] short_base_reg;
		logic [4:0] short_source_reg;
		logic [1:0] uimm;
		logic [3:0] rlist_count;
		logic [1:0] stack_extra_offset;
		logic [7:0] jt_index;
	} czd_dec_t;
endpackage : czd_pkg

//--- rtl/czd_ext_unit.sv
// Width shaping for the new loads, stores and unary register operations.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module czd_ext_unit #(
	parameter int XLEN = 32
) (
	input czd_pkg::czd_op_t op,
	input wire logic [XLEN-1:0] din,
	output logic [XLEN-1:0] dout
);
	always_comb begin
		dout = din;
		case (op)
			czd_pkg::OP_LBU, czd_pkg::OP_ZEXTB, czd_pkg::OP_SB: begin
				dout = {{(XLEN-8){1'b0}}, din[7:0]}; // RULE15 RULE21
			end
			czd_pkg::OP_LHU, czd_pkg::OP_ZEXTH, czd_pkg::OP_SH: begin
				dout = {{(XLEN-16){1'b0}}, din[15:0]}; // RULE17 RULE22
			end
			czd_pkg::OP_LH, czd_pkg::OP_SEXTH: begin
				dout = {{(XLEN-16){din[15]}}, din[15:0]}; // RULE18
			end
			czd_pkg::OP_SEXTB: begin
				dout = {{(XLEN-8){din[7]}}, din[7:0]};
			end
			czd_pkg::OP_ZEXTW: begin
				// On a 32-bit build this op never decodes, so the loop does nothing there.
				for (int i = 32; i < XLEN; i++) begin
					dout[i] = 1'b0;
				end
			end
			czd_pkg::OP_NOT: begin
				dout = ~din; // RULE23
			end
			default: begin
				dout = din;
			end
		endcase
	end
endmodule : czd_ext_unit

//--- rtl/czd_decoder.sv
// Decoder for the 16-bit code-size subsets and the shaping of their operands and results.
// Assumes configuration inputs and the execute port come from logic on clk, so none is synchronised.
//
// What this block does
// RULE1 - Single-float compressed load/store subset is never enabled on a 64-bit build.
// RULE2 - Single-float subset needs the base compressed subset and single-precision float.
// RULE3 - Double-float subset needs the base compressed subset and double-precision float.
// RULE4 - Simple subset needs base; multiply needs multiply support, sign-extend byte needs bit-manip.
// RULE5 - Compressed multiply decodes in the shared arithmetic register format.
// RULE6 - Zero-extend word decodes only on 64-bit builds; other simple ops on both.
// RULE7 - Push/pop and table jump never coexist with the double-float subset.
// RULE8 - Push/pop and pair moves need the base subset; expand into plain instructions.
// RULE9 - A register list holds return address plus zero to twelve saved registers.
// RULE10 - The list ending at saved register ten is never produced.
// RULE11 - Pair moves copy two saved registers s0-s7 to a0/a1 or back, distinct; the code checks distinctness for OP_MVSA01 only.
// RULE12 - Table jump needs base subset and CSR access; its CSR needs state enable.
// RULE13 - Major function field is bits 15..10, quadrant the lowest two bits.
// RULE14 - Byte load offset bit 1 is parcel bit 5, bit 0 is parcel bit 6.
// RULE15 - Unsigned byte load zero-extends the byte to register width.
// RULE16 - Halfword load offset bit 1 is parcel bit 5, bit 0 is zero.
// RULE17 - Unsigned halfword load zero-extends sixteen bits.
// RULE18 - Signed halfword load sign-extends sixteen bits.
// RULE19 - Three-bit register fields select registers eight to fifteen.
// RULE20 - Sign-extend word is add-immediate-word with zero; no separate decode.
// RULE21 - Byte store writes the low byte of the source to base plus offset.
// RULE22 - Halfword store writes the low halfword of the source to base plus offset.
// RULE23 - Not replaces its register with the one's complement.
// RULE24 - Encodings of a disabled or absent subset are flagged illegal.
`timescale 1ns/1ps
module czd_decoder #(
	parameter int XLEN = 32
) (
	input wire logic clk,
	input wire logic rstn,
	input czd_pkg::czd_cfg_t cfg,
	input wire logic instr_valid,
	input wire logic [15:0] instr,
	input wire logic ex_valid,
	input czd_pkg::czd_op_t ex_op,
	input wire logic [XLEN-1:0] ex_data,
	input wire logic [XLEN-1:0] ex_base,
	input wire logic [1:0] ex_uimm,
	output czd_pkg::czd_dec_t dec,
	output czd_pkg::czd_en_t en,
	output logic res_valid,
	output logic [XLEN-1:0] res_data,
	output logic [XLEN-1:0] res_addr
);
	localparam bit RV64 = (XLEN == 64);

	typedef struct packed {
		czd_pkg::czd_dec_t dec;
		czd_pkg::czd_en_t en;
		logic res_valid;
		logic [XLEN-1:0] res_data;
		logic [XLEN-1:0] res_addr;
	} czd_state_t;

	czd_state_t state_ff;
	czd_state_t nxt_state;
	logic [XLEN-1:0] ext_data;

	// Three-bit register field into x8..x15.
	function automatic logic [4:0] prime_reg(input logic [2:0] f);
		prime_reg = {czd_pkg::PRIME_BASE, f}; // RULE19
	endfunction : prime_reg

	// Saved-register field of the pair moves: s0/s1 are x8/x9, s2..s7 are x18..x23.
	function automatic logic [4:0] sreg(input logic [2:0] f);
		if (f < 3'h2) begin
			sreg = czd_pkg::SREG_LOW + {2'h0, f};
		end else begin
			sreg = czd_pkg::SREG_HIGH + {2'h0, f} - 5'h02;
		end
	endfunction : sreg

	czd_ext_unit #(.XLEN(XLEN)) u_ext (
		.op(ex_op),
		.din(ex_data),
		.dout(ext_data)
	);

	always_comb begin
		logic [5:0] f6;
		logic [2:0] f3;
		logic [1:0] quad;
		logic [1:0] fn2;
		logic [1:0] pp2;
		logic [4:0] cu;
		logic [3:0] rl;
		logic [2:0] r1;
		logic [2:0] r2;
		czd_pkg::czd_dec_t d;
		f6 = instr[czd_pkg::F6_HI:czd_pkg::F6_LO]; // RULE13
		f3 = instr[czd_pkg::F3_HI:czd_pkg::F3_LO];
		quad = instr[czd_pkg::QD_HI:czd_pkg::QD_LO]; // RULE13
		fn2 = instr[czd_pkg::FN2_HI:czd_pkg::FN2_LO];
		// The push/pop selector sits above the register list, so it cannot share the move selector bits.
		pp2 = instr[czd_pkg::PPF_HI:czd_pkg::PPF_LO];
		cu = instr[czd_pkg::CU_HI:czd_pkg::CU_LO];
		rl = instr[czd_pkg::RL_HI:czd_pkg::RL_LO];
		r1 = instr[czd_pkg::R1_HI:czd_pkg::R1_LO];
		r2 = instr[czd_pkg::R2_HI:czd_pkg::R2_LO];
		nxt_state = state_ff;

		// Enables are resolved from the configuration; conflicts drop the later subset.
		nxt_state.en.zcf = !RV64 && cfg.want_zcf && cfg.zca && cfg.f; // RULE1 RULE2
		nxt_state.en.zcd = cfg.want_zcd && cfg.zca && cfg.d; // RULE3
		nxt_state.en.zcb = cfg.want_zcb && cfg.zca; // RULE4
		nxt_state.en.zcmp = cfg.want_zcmp && cfg.zca && !nxt_state.en.zcd; // RULE7 RULE8
		nxt_state.en.zcmt = cfg.want_zcmt && cfg.zca && cfg.zicsr && !nxt_state.en.zcd; // RULE7 RULE12
		nxt_state.en.jvt_stateen = nxt_state.en.zcmt && cfg.stateen; // RULE12

		d = '0;
		d.op = czd_pkg::OP_NONE;
		d.valid = instr_valid;
		d.major_function_field = f6;
		d.short_base_reg = prime_reg(r1); // RULE19
		d.short_source_reg = prime_reg(r2);
		d.rd = prime_reg(r2);
		case (quad)
			czd_pkg::Q0: begin
				if (f6 == czd_pkg::F6_LBU) begin
					d.op = czd_pkg::OP_LBU;
					d.uimm = {instr[czd_pkg::UIMM1_BIT], instr[czd_pkg::UIMM0_BIT]}; // RULE14
					d.illegal = !state_ff.en.zcb; // RULE24
				end else if (f6 == czd_pkg::F6_LH) begin
					d.op = instr[czd_pkg::FN1_BIT] ? czd_pkg::OP_LH : czd_pkg::OP_LHU;
					d.uimm = {instr[czd_pkg::UIMM1_BIT], 1'b0}; // RULE16
					d.illegal = !state_ff.en.zcb; // RULE24
				end else if (f6 == czd_pkg::F6_SB) begin
					d.op = czd_pkg::OP_SB;
					d.rd = '0;
					d.uimm = {instr[czd_pkg::UIMM1_BIT], instr[czd_pkg::UIMM0_BIT]};
					d.illegal = !state_ff.en.zcb; // RULE24
				end else if (f6 == czd_pkg::F6_SH) begin
					d.op = instr[czd_pkg::FN1_BIT] ? czd_pkg::OP_RSVD : czd_pkg::OP_SH;
					d.rd = '0;
					d.uimm = {instr[czd_pkg::UIMM1_BIT], 1'b0}; // RULE16
					d.illegal = !state_ff.en.zcb || instr[czd_pkg::FN1_BIT]; // RULE24
				end else if (f3 == czd_pkg::F3_FD || f3 == czd_pkg::F3_FSD) begin
					d.op = (f3 == czd_pkg::F3_FD) ? czd_pkg::OP_FLD : czd_pkg::OP_FSD;
					d.illegal = !state_ff.en.zcd; // RULE3 RULE24
				end else if (f3 == czd_pkg::F3_FLW || f3 == czd_pkg::F3_FSW) begin
					// On a 64-bit build these slots belong to the base doubleword forms.
					if (!RV64) begin
						d.op = (f3 == czd_pkg::F3_FLW) ? czd_pkg::OP_FLW : czd_pkg::OP_FSW;
						d.illegal = !state_ff.en.zcf; // RULE1 RULE24
					end
				end
			end
			czd_pkg::Q1: begin
				// Sign-extend word is the base add-immediate-word form, left to the base decoder.
				if (f6 == czd_pkg::F6_CA && fn2 == czd_pkg::FN2_MUL) begin // RULE5 RULE20
					d.op = czd_pkg::OP_MUL;
					d.rd = prime_reg(r1);
					d.illegal = !(state_ff.en.zcb && cfg.mul); // RULE4 RULE24
				end else if (f6 == czd_pkg::F6_CA && fn2 == czd_pkg::FN2_CU) begin
					d.rd = prime_reg(r1);
					d.illegal = !state_ff.en.zcb; // RULE24
					case (cu)
						czd_pkg::CU_ZEXTB: d.op = czd_pkg::OP_ZEXTB;
						czd_pkg::CU_SEXTB: begin
							d.op = czd_pkg::OP_SEXTB;
							d.illegal = !(state_ff.en.zcb && cfg.zbb); // RULE4
						end
						czd_pkg::CU_ZEXTH: begin
							d.op = czd_pkg::OP_ZEXTH;
							d.illegal = !(state_ff.en.zcb && cfg.zbb);
						end
						czd_pkg::CU_SEXTH: begin
							d.op = czd_pkg::OP_SEXTH;
							d.illegal = !(state_ff.en.zcb && cfg.zbb);
						end
						czd_pkg::CU_ZEXTW: begin
							d.op = czd_pkg::OP_ZEXTW;
							d.illegal = !(RV64 && state_ff.en.zcb && cfg.zba); // RULE6
						end
						czd_pkg::CU_NOT: d.op = czd_pkg::OP_NOT; // RULE23
						default: begin
							d.op = czd_pkg::OP_RSVD;
							d.illegal = 1'b1;
						end
					endcase
				end
			end
			czd_pkg::Q2: begin
				if (f3 == czd_pkg::F3_FD) begin
					d.op = czd_pkg::OP_FLD;
					d.illegal = !state_ff.en.zcd; // RULE24
				end else if (f3 == czd_pkg::F3_FLW || f3 == czd_pkg::F3_FSW) begin
					if (!RV64) begin
						d.op = (f3 == czd_pkg::F3_FLW) ? czd_pkg::OP_FLW : czd_pkg::OP_FSW;
						d.illegal = !state_ff.en.zcf; // RULE24
					end
				end else if (f3 == czd_pkg::F3_FSD && state_ff.en.zcd) begin
					d.op = czd_pkg::OP_FSD; // RULE7
				end else if (f6 == czd_pkg::F6_PPA || f6 == czd_pkg::F6_PPB) begin
					d.rd = czd_pkg::REG_RA;
					d.short_base_reg = czd_pkg::REG_SP;
					d.stack_extra_offset = instr[czd_pkg::SP_HI:czd_pkg::SP_LO];
					d.rlist_count = rl - czd_pkg::RLIST_BIAS;
					if (rl == czd_pkg::RLIST_ALL) begin
						d.rlist_count = czd_pkg::RCNT_MAX; // RULE9 RULE10
					end
					if (pp2 == czd_pkg::PP_LO) begin
						d.op = (f6 == czd_pkg::F6_PPA) ? czd_pkg::OP_PUSH : czd_pkg::OP_POPRETZ;
					end else if (pp2 == czd_pkg::PP_HI) begin
						d.op = (f6 == czd_pkg::F6_PPA) ? czd_pkg::OP_POP : czd_pkg::OP_POPRET;
					end else begin
						d.op = czd_pkg::OP_RSVD;
					end
					d.illegal = !state_ff.en.zcmp || rl < czd_pkg::RLIST_MIN || d.op == czd_pkg::OP_RSVD; // RULE8 RULE9
				end else if (f6 == czd_pkg::F6_MV) begin
					d.short_base_reg = sreg(r1); // RULE11
					d.short_source_reg = sreg(r2);
					d.rd = czd_pkg::REG_A0;
					if (fn2 == czd_pkg::FN2_MVSA) begin
						d.op = czd_pkg::OP_MVSA01;
						d.illegal = !state_ff.en.zcmp || r1 == r2; // RULE11
					end else if (fn2 == czd_pkg::FN2_MVA) begin
						d.op = czd_pkg::OP_MVA01S;
						d.illegal = !state_ff.en.zcmp; // RULE8
					end else begin
						d.op = czd_pkg::OP_RSVD;
						d.illegal = 1'b1;
					end
				end else if (f6 == czd_pkg::F6_JT) begin
					d.jt_index = instr[czd_pkg::JT_HI:czd_pkg::JT_LO];
					d.op = (d.jt_index < czd_pkg::JT_JALT_MIN) ? czd_pkg::OP_JT : czd_pkg::OP_JALT;
					d.illegal = !state_ff.en.zcmt; // RULE12 RULE24
				end else if (f3 == czd_pkg::F3_FSD) begin
					d.op = czd_pkg::OP_RSVD;
					d.illegal = 1'b1; // RULE24
				end
			end
			default: begin
				d.op = czd_pkg::OP_NONE;
			end
		endcase
		d.claimed = instr_valid && d.op != czd_pkg::OP_NONE;
		d.illegal = d.claimed && d.illegal;
		nxt_state.dec = d;

		// Address is formed from the offset the decode stage handed back with the operand.
		nxt_state.res_valid = ex_valid;
		if (ex_valid) begin
			nxt_state.res_data = ext_data; // RULE15 RULE17 RULE18 RULE21 RULE22 RULE23
			nxt_state.res_addr = ex_base + {{(XLEN-2){1'b0}}, ex_uimm}; // RULE14 RULE21 RULE22
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign dec = state_ff.dec;
	assign en = state_ff.en;
	assign res_valid = state_ff.res_valid;
	assign res_data = state_ff.res_data;
	assign res_addr = state_ff.res_addr;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	chk_zcf_only_rv32: assert property (en.zcf |-> !RV64 && $past(cfg.zca && cfg.f)) // RULE1 RULE2
		else $error("single-float subset enabled without its prerequisites");
	chk_zcd_deps: assert property (en.zcd |-> $past(cfg.zca && cfg.d && cfg.want_zcd)) // RULE3
		else $error("double-float subset enabled without its prerequisites");
	chk_zcd_exclusive: assert property (!(en.zcd && (en.zcmp || en.zcmt))) // RULE7
		else $error("push/pop or table jump enabled together with double-float subset");
	chk_field_source: assert property ($past(instr_valid) |-> dec.major_function_field == $past(instr[15:10])) // RULE13
		else $error("major function field not taken from bits 15..10");
	chk_rlist_range: assert property (dec.op inside {czd_pkg::OP_PUSH, czd_pkg::OP_POP} && !dec.illegal
		|-> dec.rlist_count >= 4'h1 && dec.rlist_count <= czd_pkg::RCNT_MAX && dec.rlist_count != czd_pkg::RCNT_GAP) // RULE9 RULE10
		else $error("register list count out of range");
	chk_mvsa_distinct: assert property (dec.op == czd_pkg::OP_MVSA01 && !dec.illegal
		|-> dec.short_base_reg != dec.short_source_reg) // RULE11
		else $error("pair move names the same saved register twice");
	chk_prime_regs: assert property (dec.op inside {czd_pkg::OP_LBU, czd_pkg::OP_LH, czd_pkg::OP_LHU, czd_pkg::OP_SB}
		|-> dec.short_base_reg[4:3] == 2'h1 && dec.short_source_reg[4:3] == 2'h1) // RULE19
		else $error("compressed register outside x8..x15");
	chk_lbu_offset: assert property ($past(instr_valid) && dec.op == czd_pkg::OP_LBU
		|-> dec.uimm == {$past(instr[5]), $past(instr[6])}) // RULE14
		else $error("byte load offset bits misplaced");
	chk_half_offset: assert property (dec.op inside {czd_pkg::OP_LH, czd_pkg::OP_LHU, czd_pkg::OP_SH}
		|-> dec.uimm[0] == 1'b0) // RULE16
		else $error("halfword offset bit 0 not zero");
	chk_lh_sign: assert property (ex_valid && ex_op == czd_pkg::OP_LH
		|=> res_data == {{(XLEN-16){$past(ex_data[15])}}, $past(ex_data[15:0])}) // RULE18
		else $error("signed halfword load not sign extended");
	chk_lbu_zero: assert property (ex_valid && ex_op == czd_pkg::OP_LBU
		|=> res_data == {{(XLEN-8){1'b0}}, $past(ex_data[7:0])} && res_valid) // RULE15
		else $error("unsigned byte load not zero extended");
	chk_mul_gate: assert property (dec.op == czd_pkg::OP_MUL && !dec.illegal |-> $past(cfg.mul) && $past(en.zcb)) // RULE4 RULE24
		else $error("compressed multiply accepted without multiply support");
	chk_zextw_rv64: assert property (dec.op == czd_pkg::OP_ZEXTW && !dec.illegal |-> RV64) // RULE6
		else $error("zero-extend word accepted on a 32-bit build");

	cov_push: cover property (dec.valid && dec.op == czd_pkg::OP_PUSH && !dec.illegal);
	cov_lh: cover property (ex_valid && ex_op == czd_pkg::OP_LH ##1 res_valid);
	cov_illegal: cover property (dec.valid && dec.illegal);
	cov_jt: cover property (dec.op == czd_pkg::OP_JALT && !dec.illegal);
endmodule : czd_decoder

//--- verif/czd_fetch_model.sv
// Fetch-side model that hands one 16-bit parcel per request to the decoder.
// Assumes requests are raised by the bench just after a rising clk edge.
`timescale 1ns/1ps
module czd_fetch_model (
	input wire logic clk,
	input wire logic rstn,
	input wire logic req,
	input wire logic [15:0] parcel,
	output logic instr_valid,
	output logic [15:0] instr
);
	logic [15:0] last_ff;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			last_ff <= 16'h0000;
		end else if (req) begin
			last_ff <= parcel;
		end
	end
	// Between parcels the bus shows the inverse of the last parcel, so stale data never looks valid.
	assign instr_valid = req;
	assign instr = req ? parcel : ~last_ff;
endmodule : czd_fetch_model

//--- verif/compressed_ext_decoder_tb.sv
// Self-checking bench for the compressed decoder, built for 32-bit and 64-bit side by side.
// Assumes the fetch model in its own file; both builds see the same stimulus.
`timescale 1ns/1ps
module compressed_ext_decoder_tb;
	logic clk;
	logic rstn;
	logic req;
	logic [15:0] parcel;
	logic instr_valid;
	logic [15:0] instr;
	logic ex_valid;
	czd_pkg::czd_op_t ex_op;
	logic [31:0] ex_data;
	logic [31:0] ex_base;
	logic [1:0] ex_uimm;
	czd_pkg::czd_cfg_t cfg;
	czd_pkg::czd_cfg_t base_cfg;
	czd_pkg::czd_dec_t dec;
	czd_pkg::czd_dec_t dec64;
	czd_pkg::czd_en_t en;
	czd_pkg::czd_en_t en64;
	logic res_valid;
	logic [31:0] res_data;
	logic [31:0] res_addr;
	int error_cnt;
	int check_count;

	czd_fetch_model fetch_u (.clk(clk), .rstn(rstn), .req(req), .parcel(parcel), .instr_valid(instr_valid),
		.instr(instr));
	czd_decoder #(.XLEN(32)) dut_u (.clk(clk), .rstn(rstn), .cfg(cfg), .instr_valid(instr_valid), .instr(instr),
		.ex_valid(ex_valid), .ex_op(ex_op), .ex_data(ex_data), .ex_base(ex_base), .ex_uimm(ex_uimm),
		.dec(dec), .en(en), .res_valid(res_valid), .res_data(res_data), .res_addr(res_addr));
	czd_decoder #(.XLEN(64)) dut64_u (.clk(clk), .rstn(rstn), .cfg(cfg), .instr_valid(instr_valid),
		.instr(instr), .ex_valid(ex_valid), .ex_op(ex_op), .ex_data({32'h0, ex_data}),
		.ex_base({32'h0, ex_base}), .ex_uimm(ex_uimm), .dec(dec64), .en(en64), .res_valid(),
		.res_data(), .res_addr());

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task finish_test;
		$display("errors %0d checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : finish_test

	task check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// Enables are registered and decode uses them a cycle later, hence two edges.
	task set_cfg(input czd_pkg::czd_cfg_t c);
		req = 1'b0;
		cfg = c;
		repeat (2) @(posedge clk);
		#1;
	endtask : set_cfg

	// Leaves req high so that callers may issue parcels back to back.
	task dcd(input logic [15:0] p, input czd_pkg::czd_op_t op, input logic ill, input logic w64);
		czd_pkg::czd_dec_t d;
		req = 1'b1;
		parcel = p;
		@(posedge clk);
		#1;
		d = w64 ? dec64 : dec;
		check({d.valid, d.claimed, d.illegal}, {2'b11, ill});
		if (!ill) begin
			check(d.op, op);
		end
	endtask : dcd

	task exe(input czd_pkg::czd_op_t op, input logic [31:0] d, input logic [31:0] exp);
		ex_valid = 1'b1;
		ex_op = op;
		ex_data = d;
		ex_base = 32'h0000_1000;
		ex_uimm = 2'h3;
		@(posedge clk);
		#1;
		check(res_valid, 32'h1);
		check(res_data, exp);
		check(res_addr, 32'h0000_1003);
	endtask : exe

	task s_enables;
		czd_pkg::czd_cfg_t c;
		c = base_cfg;
		set_cfg(c);
		check(en, 32'h2f);
		check(en64.zcf, 32'h0);
		c.f = 1'b0;
		set_cfg(c);
		check(en.zcf, 32'h0);
		c = base_cfg;
		c.want_zcd = 1'b1;
		set_cfg(c);
		check(en.zcd, 32'h0);
		c.d = 1'b1;
		set_cfg(c);
		check(en[4:1], 32'hc);
		c = base_cfg;
		c.zicsr = 1'b0;
		set_cfg(c);
		check(en.zcmt, 32'h0);
		c.zca = 1'b0;
		set_cfg(c);
		check(en.zcb, 32'h0);
		check(en.zcmp, 32'h0);
	endtask : s_enables

	task s_loads;
		logic [2:0] r;
		set_cfg(base_cfg);
		for (int i = 0; i < 8; i++) begin
			r = 3'(i);
			dcd({czd_pkg::F6_LBU, r, 2'b10, ~r, czd_pkg::Q0}, czd_pkg::OP_LBU, 1'b0, 1'b0);
			check(dec.major_function_field, 32'h20);
			check(dec.uimm, 32'h1);
			check(dec.short_base_reg, {27'h0, 2'b01, r});
			check(dec.rd, {27'h0, 2'b01, ~r});
		end
		dcd({czd_pkg::F6_LBU, 3'h2, 2'b01, 3'h3, czd_pkg::Q0}, czd_pkg::OP_LBU, 1'b0, 1'b0);
		check(dec.uimm, 32'h2);
		dcd({czd_pkg::F6_LH, 3'h2, 2'b01, 3'h3, czd_pkg::Q0}, czd_pkg::OP_LHU, 1'b0, 1'b0);
		check(dec.uimm, 32'h2);
		dcd({czd_pkg::F6_LH, 3'h2, 2'b10, 3'h3, czd_pkg::Q0}, czd_pkg::OP_LH, 1'b0, 1'b0);
		check(dec.uimm, 32'h0);
		dcd({3'h3, 11'h000, czd_pkg::Q0}, czd_pkg::OP_FLW, 1'b0, 1'b0);
		check(dec64.claimed, 32'h0);
	endtask : s_loads

	task s_arith;
		czd_pkg::czd_cfg_t c;
		dcd({czd_pkg::F6_CA, 3'h1, 2'b10, 3'h2, czd_pkg::Q1}, czd_pkg::OP_MUL, 1'b0, 1'b0);
		check(dec.short_source_reg, 32'h0a);
		dcd({czd_pkg::F6_CA, 3'h3, czd_pkg::CU_SEXTB, czd_pkg::Q1}, czd_pkg::OP_SEXTB, 1'b0, 1'b0);
		dcd({czd_pkg::F6_CA, 3'h3, czd_pkg::CU_NOT, czd_pkg::Q1}, czd_pkg::OP_NOT, 1'b0, 1'b0);
		dcd({czd_pkg::F6_CA, 3'h3, czd_pkg::CU_ZEXTW, czd_pkg::Q1}, czd_pkg::OP_NONE, 1'b1, 1'b0);
		check(dec64.op, czd_pkg::OP_ZEXTW);
		c = base_cfg;
		c.mul = 1'b0;
		c.zbb = 1'b0;
		set_cfg(c);
		dcd({czd_pkg::F6_CA, 3'h1, 2'b10, 3'h2, czd_pkg::Q1}, czd_pkg::OP_NONE, 1'b1, 1'b0);
		dcd({czd_pkg::F6_CA, 3'h3, czd_pkg::CU_SEXTB, czd_pkg::Q1}, czd_pkg::OP_NONE, 1'b1, 1'b0);
		c.want_zcb = 1'b0;
		set_cfg(c);
		dcd({czd_pkg::F6_LBU, 3'h2, 2'b01, 3'h3, czd_pkg::Q0}, czd_pkg::OP_NONE, 1'b1, 1'b0);
	endtask : s_arith

	task s_stack;
		czd_pkg::czd_cfg_t c;
		logic [3:0] u;
		set_cfg(base_cfg);
		for (int i = 0; i < 16; i++) begin
			u = 4'(i);
			dcd({czd_pkg::F6_PPA, 2'b00, u, 2'h1, czd_pkg::Q2}, czd_pkg::OP_PUSH, u < 4'h4, 1'b0);
			if (u >= 4'h4) begin
				check(dec.rlist_count, (u == 4'hf) ? 4'hd : u - 4'h3);
			end
		end
		dcd({czd_pkg::F6_MV, 3'h2, 2'b01, 3'h2, czd_pkg::Q2}, czd_pkg::OP_NONE, 1'b1, 1'b0);
		dcd({czd_pkg::F6_MV, 3'h1, 2'b01, 3'h7, czd_pkg::Q2}, czd_pkg::OP_MVSA01, 1'b0, 1'b0);
		check({dec.rd, dec.short_base_reg, dec.short_source_reg}, {17'h0, 5'h0a, 5'h09, 5'h17});
		dcd({czd_pkg::F6_MV, 3'h0, 2'b11, 3'h0, czd_pkg::Q2}, czd_pkg::OP_MVA01S, 1'b0, 1'b0);
		dcd({czd_pkg::F6_PPA, 2'b10, 4'h5, 2'h2, czd_pkg::Q2}, czd_pkg::OP_POP, 1'b0, 1'b0);
		check({dec.rlist_count, dec.stack_extra_offset}, {26'h0, 4'h2, 2'h2});
		dcd({czd_pkg::F6_PPB, 2'b00, 4'hf, 2'h3, czd_pkg::Q2}, czd_pkg::OP_POPRETZ, 1'b0, 1'b0);
		dcd({czd_pkg::F6_PPB, 2'b01, 4'h4, 2'h0, czd_pkg::Q2}, czd_pkg::OP_NONE, 1'b1, 1'b0);
		dcd({czd_pkg::F6_JT, 8'h05, czd_pkg::Q2}, czd_pkg::OP_JT, 1'b0, 1'b0);
		check(dec.jt_index, 32'h05);
		dcd({czd_pkg::F6_JT, 8'h21, czd_pkg::Q2}, czd_pkg::OP_JALT, 1'b0, 1'b0);
		c = base_cfg;
		c.d = 1'b1;
		c.want_zcd = 1'b1;
		set_cfg(c);
		// With the double-float subset on, the push encoding belongs to the stack store.
		dcd({czd_pkg::F6_PPA, 2'b00, 4'h4, 2'h1, czd_pkg::Q2}, czd_pkg::OP_FSD, 1'b0, 1'b0);
		dcd({czd_pkg::F6_JT, 8'h05, czd_pkg::Q2}, czd_pkg::OP_FSD, 1'b0, 1'b0);
		dcd({3'h1, 11'h000, czd_pkg::Q0}, czd_pkg::OP_FLD, 1'b0, 1'b0);
	endtask : s_stack

	task s_exec;
		exe(czd_pkg::OP_LBU, 32'h1234_56f8, 32'h0000_00f8);
		exe(czd_pkg::OP_LHU, 32'h1234_8001, 32'h0000_8001);
		exe(czd_pkg::OP_LH, 32'h1234_8001, 32'hffff_8001);
		exe(czd_pkg::OP_LH, 32'hffff_7001, 32'h0000_7001);
		exe(czd_pkg::OP_SB, 32'hcafe_12a5, 32'h0000_00a5);
		exe(czd_pkg::OP_SH, 32'hcafe_12a5, 32'h0000_12a5);
		exe(czd_pkg::OP_NOT, 32'h0f0f_1234, 32'hf0f0_edcb);
		ex_valid = 1'b0;
		@(posedge clk);
		#1;
		check(res_valid, 32'h0);
		check(res_data, 32'hf0f0_edcb);
	endtask : s_exec

	initial begin
		repeat (2000) @(posedge clk);
		error_cnt++;
		finish_test();
	end

	initial begin
		rstn = 1'b0;
		req = 1'b0;
		parcel = 16'h0000;
		ex_valid = 1'b0;
		ex_op = czd_pkg::OP_NONE;
		ex_data = 32'h0;
		ex_base = 32'h0;
		ex_uimm = 2'h0;
		cfg = '0;
		error_cnt = 0;
		check_count = 0;
		base_cfg = '{zca: 1'b1, f: 1'b1, d: 1'b0, mul: 1'b1, zbb: 1'b1, zba: 1'b1, zicsr: 1'b1, stateen: 1'b1,
			want_zcf: 1'b1, want_zcd: 1'b0, want_zcb: 1'b1, want_zcmp: 1'b1, want_zcmt: 1'b1};
		repeat (5) @(posedge clk);
		#1;
		rstn = 1'b1;
		s_enables();
		s_loads();
		s_arith();
		s_stack();
		s_exec();
		finish_test();
	end
endmodule : compressed_ext_decoder_tb
